// [logic/smps_pkg.sv]
// Constants shared by the stop-mode power sequencer.
// Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
package smps_pkg;

	// Register byte addresses.
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] ACK_ADDR    = 8'h08;

	// Control register field positions.
	localparam int CTRL_STOPEN  = 0;
	localparam int CTRL_DEEPSEL = 1;
	localparam int CTRL_DBGEN   = 2;
	localparam int CTRL_LVDEN   = 3;
	localparam int CTRL_LVDSTOP = 4;
	localparam int CTRL_OSCKEEP = 5;
	localparam int CTRL_ADCACK  = 6;
	localparam int CTRL_WIDTH   = 7;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;

	// Status register field positions.
	localparam int STAT_MODE_LO = 0;
	localparam int STAT_MODE_HI = 1;
	localparam int STAT_WAKEFLG = 2;
	localparam int STAT_PINLAT  = 3;

	// Acknowledge register field position.
	localparam int ACK_RELEASE = 0;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operating modes of the sequencer.
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_LIGHT = 2'b01,
		MODE_DEEP  = 2'b10,
		MODE_DEBUG = 2'b11
	} smps_mode_e;

endpackage : smps_pkg

// [logic/smps_top.sv]
// Stop-mode power sequencer: picks light or deep stop, gates clocks,
// steers the regulator, pin latches and wake-up resets.
// Assumes synchronous single-cycle event inputs from the core and debug
// port, and an AXI4-Lite master that keeps one read and one write open.
`timescale 1ns/1ns
module smps_top (
	// Clock and reset.
	input  wire logic                    ref_clk,
	input  wire logic                    resetn,
	// AXI4-Lite write address and data.
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	output logic [1:0]                   s_axi_bresp,
	// AXI4-Lite read address and data.
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	input  wire logic [7:0]              s_axi_araddr,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	// Core events.
	input  wire logic                    stopInstr,
	// Wake sources.
	input  wire logic                    wakeResetPin,
	input  wire logic                    wakeIrqPin,
	input  wire logic                    wakePeriodicTimer,
	input  wire logic                    wakeLightIrq,
	input  wire logic                    wakeKeypad,
	// Debug port events.
	input  wire logic                    bgndCmd,
	input  wire logic                    debugGoCmd,
	input  wire logic                    memStatusCmd,
	// Clock gating and power control.
	output logic                         periphClkEn,
	output logic                         debugClkEn,
	output logic                         clkGenActive,
	output logic                         clkGenStandby,
	output logic                         oscRun,
	output logic                         regulatorStandby,
	output logic                         coreStandby,
	output logic                         adcStandby,
	output logic                         keypadEnable,
	output logic                         pinLatch,
	// Resets and debug answers.
	output logic                         wakeBlockReset,
	output logic                         coreReset,
	output logic                         illegalOpReset,
	output logic                         debugActive,
	output logic                         memStatusErr,
	output logic                         memStatusOk
);
	import smps_pkg::*;

	// Registers and sampled stop-entry bits.
	logic [CTRL_WIDTH-1:0] ctrl_r;
	logic                  wakeFlag_r;
	smps_mode_e            mode_r;
	smps_mode_e            mode_nxt;
	logic                  dbgSmp_r;
	logic                  lvdSmp_r;
	logic                  oscSmp_r;
	logic                  adcSmp_r;
	logic                  dbgSmp_nxt;
	logic                  lvdSmp_nxt;
	logic                  oscSmp_nxt;
	logic                  adcSmp_nxt;
	logic                  lightReq;
	logic                  deepReq;
	logic                  deepWake;
	logic                  lightRstWake;

	// Bus slave state.
	logic                  awHeld_r;
	logic                  wHeld_r;
	logic [7:0]            awAddr_r;
	logic [31:0]           wData_r;
	logic [3:0]            wStrb_r;
	logic                  wrFire;
	logic                  ackWrite;
	logic                  ctrlWrite;

	// Stop request decode from the live control bits.
	always_comb begin
		logic forceLight;
		forceLight = ctrl_r[CTRL_DBGEN]
			| (ctrl_r[CTRL_LVDEN] & ctrl_r[CTRL_LVDSTOP]);
		lightReq = stopInstr & ctrl_r[CTRL_STOPEN] & (mode_r == MODE_RUN)
			& (~ctrl_r[CTRL_DEEPSEL] | forceLight);
		deepReq = stopInstr & ctrl_r[CTRL_STOPEN] & (mode_r == MODE_RUN)
			& ctrl_r[CTRL_DEEPSEL] & ~forceLight;
	end

	// Wake decode for each stop mode.
	assign deepWake = (mode_r == MODE_DEEP)
		& (wakeResetPin | wakeIrqPin | wakePeriodicTimer);
	assign lightRstWake = (mode_r == MODE_LIGHT) & wakeResetPin;

	// Next mode.
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			MODE_RUN: begin
				if (deepReq) begin
					mode_nxt = MODE_DEEP;
				end else if (lightReq) begin
					mode_nxt = MODE_LIGHT;
				end else if (bgndCmd & ctrl_r[CTRL_DBGEN]) begin
					mode_nxt = MODE_DEBUG;
				end
			end
			MODE_LIGHT: begin
				if (wakeResetPin | wakeLightIrq | wakeKeypad
					| wakePeriodicTimer | wakeIrqPin) begin
					mode_nxt = MODE_RUN;
				end else if (bgndCmd & dbgSmp_r) begin
					mode_nxt = MODE_DEBUG;
				end
			end
			MODE_DEEP: begin
				if (deepWake) begin
					mode_nxt = MODE_RUN;
				end
			end
			MODE_DEBUG: begin
				if (debugGoCmd) begin
					mode_nxt = MODE_RUN;
				end
			end
		endcase
	end

	// Samples of the mode bits taken at the stop instruction.
	always_comb begin
		dbgSmp_nxt = dbgSmp_r;
		lvdSmp_nxt = lvdSmp_r;
		oscSmp_nxt = oscSmp_r;
		adcSmp_nxt = adcSmp_r;
		if (lightReq | deepReq) begin
			dbgSmp_nxt = ctrl_r[CTRL_DBGEN];
			lvdSmp_nxt = ctrl_r[CTRL_LVDEN] & ctrl_r[CTRL_LVDSTOP];
			oscSmp_nxt = ctrl_r[CTRL_OSCKEEP];
			adcSmp_nxt = ctrl_r[CTRL_ADCACK];
		end
	end

	// Mode and sample registers.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mode_r   <= MODE_RUN;
			dbgSmp_r <= 1'b0;
			lvdSmp_r <= 1'b0;
			oscSmp_r <= 1'b0;
			adcSmp_r <= 1'b0;
		end else begin
			mode_r   <= mode_nxt;
			dbgSmp_r <= dbgSmp_nxt;
			lvdSmp_r <= lvdSmp_nxt;
			oscSmp_r <= oscSmp_nxt;
			adcSmp_r <= adcSmp_nxt;
		end
	end

	// Power and clock outputs follow the next mode; reset looks like run.
	always_ff @(posedge ref_clk) begin
		unique case (resetn ? mode_nxt : MODE_RUN)
			MODE_LIGHT: begin
				periphClkEn      <= 1'b0;
				debugClkEn       <= dbgSmp_nxt;
				clkGenActive     <= dbgSmp_nxt;
				clkGenStandby    <= ~dbgSmp_nxt;
				oscRun           <= dbgSmp_nxt | oscSmp_nxt;
				regulatorStandby <= ~(dbgSmp_nxt
					| lvdSmp_nxt);
				coreStandby      <= 1'b1;
				adcStandby       <= ~adcSmp_nxt;
				keypadEnable     <= 1'b1;
			end
			MODE_DEEP: begin
				periphClkEn      <= 1'b0;
				debugClkEn       <= 1'b0;
				clkGenActive     <= 1'b0;
				clkGenStandby    <= 1'b0;
				oscRun           <= 1'b0;
				regulatorStandby <= 1'b1;
				coreStandby      <= 1'b1;
				adcStandby       <= 1'b1;
				keypadEnable     <= 1'b0;
			end
			MODE_RUN, MODE_DEBUG: begin
				periphClkEn      <= 1'b1;
				debugClkEn       <= 1'b1;
				clkGenActive     <= 1'b1;
				clkGenStandby    <= 1'b0;
				oscRun           <= 1'b1;
				regulatorStandby <= 1'b0;
				coreStandby      <= 1'b0;
				adcStandby       <= 1'b0;
				keypadEnable     <= 1'b1;
			end
		endcase
	end

	// Reset pulses for the core and the blocks emptied by deep stop.
	always_ff @(posedge ref_clk) begin
		wakeBlockReset <= resetn & deepWake;
		coreReset      <= resetn & (deepWake | lightRstWake);
		illegalOpReset <= resetn & stopInstr & ~ctrl_r[CTRL_STOPEN]
			& (mode_r == MODE_RUN);
	end

	// Debug port answers: restricted while stopped, full in debug mode.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			debugActive  <= 1'b0;
			memStatusErr <= 1'b0;
			memStatusOk  <= 1'b0;
		end else begin
			debugActive  <= (mode_nxt == MODE_DEBUG);
			memStatusErr <= memStatusCmd & ((mode_r == MODE_LIGHT)
				| (mode_r == MODE_DEEP));
			memStatusOk  <= memStatusCmd & ((mode_r == MODE_RUN)
				| (mode_r == MODE_DEBUG));
		end
	end

	// Write decode.
	assign wrFire    = awHeld_r & wHeld_r & ~s_axi_bvalid;
	assign ackWrite  = wrFire & (awAddr_r == ACK_ADDR) & wStrb_r[0]
		& wData_r[ACK_RELEASE];
	assign ctrlWrite = wrFire & (awAddr_r == CTRL_ADDR) & wStrb_r[0];

	// Control register; light stop keeps it, deep wake clears it.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (deepWake) begin
			ctrl_r <= CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl_r <= wData_r[CTRL_WIDTH-1:0];
		end
	end

	// Wake flag and pin latch; a deep event wins over an acknowledge.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wakeFlag_r <= 1'b0;
			pinLatch   <= 1'b0;
		end else begin
			if (deepWake) begin
				wakeFlag_r <= 1'b1;
			end else if (ackWrite) begin
				wakeFlag_r <= 1'b0;
			end
			if (deepReq | deepWake) begin
				pinLatch <= 1'b1;
			end else if (ackWrite) begin
				pinLatch <= 1'b0;
			end
		end
	end

	// Write channel: address and data taken in either order.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			awHeld_r     <= 1'b0;
			wHeld_r      <= 1'b0;
			awAddr_r     <= 8'h00;
			wData_r      <= 32'h0000_0000;
			wStrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= ((awAddr_r == CTRL_ADDR)
					| (awAddr_r == ACK_ADDR)) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Write ready is offered only while a slot is free.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~awHeld_r & ~(s_axi_awvalid & s_axi_awready)
				& ~s_axi_bvalid;
			s_axi_wready  <= ~wHeld_r & ~(s_axi_wvalid & s_axi_wready)
				& ~s_axi_bvalid;
		end
	end

	// Read channel: one cycle from address to data.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= 32'h0000_0000;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					CTRL_ADDR: s_axi_rdata[CTRL_WIDTH-1:0] <= ctrl_r;
					STATUS_ADDR: begin
						s_axi_rdata[STAT_MODE_HI:STAT_MODE_LO] <= mode_r;
						s_axi_rdata[STAT_WAKEFLG] <= wakeFlag_r;
						s_axi_rdata[STAT_PINLAT]  <= pinLatch;
					end
					ACK_ADDR: s_axi_rresp <= RESP_OKAY; // Reads as zero.
					default: s_axi_rresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : smps_top

// [verif/smps_core_model.sv]
// Core, peripheral and debug-host model that raises event pulses.
// Assumes the sequencer samples each event on one rising edge.
`timescale 1ns/1ns
module smps_core_model (
	// Clock.
	input  wire logic       ref_clk,
	// Event pulses, one bit each.
	output logic      [8:0] evOut
);
	logic [8:0] ev_r = 9'h000;

	// Events leave on a register so they change just after an edge.
	assign evOut = ev_r;

	// Holds the chosen events for one cycle; wake and background
	// command pulses may be raised while the device is stopped.
	task pulse(input logic [8:0] e);
		@(posedge ref_clk);
		ev_r <= e;
		@(posedge ref_clk);
		ev_r <= 9'h000;
	endtask : pulse
endmodule : smps_core_model

// [verif/smps_properties.sv]
// Port-level checks for the stop-mode power sequencer.
// Assumes one clock domain and binding into smps_top.
`timescale 1ns/1ns
module smps_properties (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic resetn,
	// Bus readiness and event inputs.
	input  wire logic s_axi_bvalid,
	input  wire logic stopInstr,
	input  wire logic wakeResetPin,
	input  wire logic wakeIrqPin,
	input  wire logic wakePeriodicTimer,
	input  wire logic bgndCmd,
	input  wire logic memStatusCmd,
	// Power and gating outputs.
	input  wire logic periphClkEn,
	input  wire logic debugClkEn,
	input  wire logic clkGenActive,
	input  wire logic clkGenStandby,
	input  wire logic oscRun,
	input  wire logic regulatorStandby,
	input  wire logic coreStandby,
	input  wire logic keypadEnable,
	input  wire logic pinLatch,
	// Resets and debug answers.
	input  wire logic wakeBlockReset,
	input  wire logic coreReset,
	input  wire logic illegalOpReset,
	input  wire logic debugActive,
	input  wire logic memStatusErr
);
	// Every check runs on the reference clock and rests in reset.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	AST_STOP_GATE: assert property (
		stopInstr && periphClkEn && !debugActive |=>
		illegalOpReset || !periphClkEn) else $error("Stop kept clocks.");
	AST_DEBUG_LIGHT: assert property (
		coreStandby && debugClkEn && !debugActive |->
		clkGenActive && oscRun && !regulatorStandby)
		else $error("Debug stop lost clock or regulator.");
	AST_DEEP_STATE: assert property (
		pinLatch && !periphClkEn && !debugClkEn && !clkGenStandby |->
		!oscRun && !clkGenActive && !keypadEnable && regulatorStandby)
		else $error("Deep stop wrong.");
	AST_DEEP_WAKE: assert property (
		wakeBlockReset |-> coreReset && periphClkEn && oscRun && pinLatch)
		else $error("Deep wake outputs wrong.");
	AST_WAKE_CAUSE: assert property (
		wakeBlockReset |-> $past(wakeResetPin) || $past(wakeIrqPin) ||
		$past(wakePeriodicTimer)) else $error("Deep wake without source.");
	AST_DEBUG_CAUSE: assert property (
		$rose(debugActive) |-> $past(bgndCmd))
		else $error("Debug mode without command.");
	AST_MEM_REFUSE: assert property (
		memStatusCmd && !periphClkEn && !debugActive |=> memStatusErr)
		else $error("Status command in stop not refused.");
	AST_LATCH_HOLD: assert property (
		$fell(pinLatch) |-> $rose(s_axi_bvalid))
		else $error("Pin latch opened without release.");
endmodule : smps_properties

bind smps_top smps_properties u_smps_properties (.ref_clk, .resetn,
	.s_axi_bvalid, .stopInstr, .wakeResetPin, .wakeIrqPin,
	.wakePeriodicTimer, .bgndCmd, .memStatusCmd, .periphClkEn, .debugClkEn,
	.clkGenActive, .clkGenStandby, .oscRun, .regulatorStandby,
	.coreStandby, .keypadEnable,
	.pinLatch, .wakeBlockReset, .coreReset, .illegalOpReset, .debugActive,
	.memStatusErr);

// [verif/tb_top.sv]
// Self-checking bench for the stop-mode power sequencer.
// Assumes the core model raises events and the bench masters the bus.
`timescale 1ns/1ns
module tb_top;
	import smps_pkg::*;
	localparam logic [8:0] EV_STOP = 9'h001, EV_IRQ = 9'h002;
	localparam logic [8:0] EV_RST = 9'h004, EV_TMR = 9'h008;
	localparam logic [8:0] EV_LIGHT = 9'h010, EV_KPD = 9'h020;
	localparam logic [8:0] EV_BGND = 9'h040, EV_GO = 9'h080;
	localparam logic [8:0] EV_MEM = 9'h100;
	localparam logic [31:0] STP = 32'h1 << CTRL_STOPEN;
	localparam logic [31:0] DSL = 32'h1 << CTRL_DEEPSEL;
	localparam logic [31:0] DBG = 32'h1 << CTRL_DBGEN;
	localparam logic [31:0] LVE = 32'h1 << CTRL_LVDEN;
	localparam logic [31:0] LVS = 32'h1 << CTRL_LVDSTOP;
	localparam logic [31:0] OSK = 32'h1 << CTRL_OSCKEEP;
	localparam logic [31:0] ADK = 32'h1 << CTRL_ADCACK;
	localparam logic [31:0] DWK = (32'h1 << STAT_WAKEFLG) |
		(32'h1 << STAT_PINLAT);
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
	logic        rrdy = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rData, d;
	logic [1:0]  bResp, rResp, r;
	logic        awRdy, wRdy, bVld, arRdy, rVld;
	logic [8:0]  evs;
	logic [9:0]  pw;
	logic [4:0]  seen = 5'h00;
	logic        periphClkEn, debugClkEn, clkGenActive, clkGenStandby;
	logic        oscRun, regulatorStandby, coreStandby, adcStandby;
	logic        keypadEnable, pinLatch, wakeBlockReset, coreReset;
	logic        illegalOpReset, debugActive, memStatusErr, memStatusOk;
	int          n_mismatch = 0, check_count = 0, cyc = 0;

	smps_core_model u_smps_core_model (.ref_clk, .evOut(evs));
	smps_top u_smps_top (.ref_clk, .resetn, .s_axi_awvalid(awv),
		.s_axi_awready(awRdy), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wRdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bVld), .s_axi_bready(brdy), .s_axi_bresp(bResp),
		.s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_araddr(ara),
		.s_axi_rvalid(rVld), .s_axi_rready(rrdy), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .stopInstr(evs[0]), .wakeIrqPin(evs[1]),
		.wakeResetPin(evs[2]), .wakePeriodicTimer(evs[3]),
		.wakeLightIrq(evs[4]), .wakeKeypad(evs[5]), .bgndCmd(evs[6]),
		.debugGoCmd(evs[7]), .memStatusCmd(evs[8]), .periphClkEn,
		.debugClkEn, .clkGenActive, .clkGenStandby, .oscRun,
		.regulatorStandby, .coreStandby, .adcStandby, .keypadEnable,
		.pinLatch, .wakeBlockReset, .coreReset, .illegalOpReset,
		.debugActive, .memStatusErr, .memStatusOk);

	// Clock at 250 MHz and a packed view of the power outputs.
	always #2 ref_clk = ~ref_clk;
	assign pw = {periphClkEn, debugClkEn, clkGenActive, clkGenStandby,
		oscRun, regulatorStandby, coreStandby, adcStandby, keypadEnable,
		pinLatch};

	// Gathers one-cycle pulses so a check cannot miss them.
	always @(posedge ref_clk) seen <= seen | {wakeBlockReset, coreReset,
		illegalOpReset, memStatusErr, memStatusOk};

	// Cuts a hang short long after the sequence should have ended.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task chk(input logic [35:0] g, input logic [35:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
		@(posedge ref_clk);
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		awa <= a;
		wd <= v;
		forever begin
			@(posedge ref_clk);
			if (awRdy) awv <= 1'b0;
			if (wRdy) wv <= 1'b0;
			if (bVld) begin
				brdy <= 1'b0;
				s = bResp;
				break;
			end
		end
		#1;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
		@(posedge ref_clk);
		arv <= 1'b1;
		rrdy <= 1'b1;
		ara <= a;
		forever begin
			@(posedge ref_clk);
			if (arRdy) arv <= 1'b0;
			if (rVld) begin
				rrdy <= 1'b0;
				v = rData;
				s = rResp;
				break;
			end
		end
		#1;
	endtask : rd

	// Fires events and waits until levels and pulses have settled.
	task ev(input logic [8:0] e);
		seen = 5'h00;
		u_smps_core_model.pulse(e);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : ev

	task t_reset;
		chk(pw, 10'h3A2);
		rd(CTRL_ADDR, d, r);
		chk({r, d}, {RESP_OKAY, 32'h0});
		wr(STATUS_ADDR, 32'hF, r);
		chk(r, RESP_SLVERR);
		rd(STATUS_ADDR, d, r);
		chk(d, 32'h0);
		rd(ACK_ADDR, d, r);
		chk(d, 32'h0);
		rd(8'h0C, d, r);
		chk(r, RESP_SLVERR);
		wr(8'h0C, 32'h1, r);
		chk(r, RESP_SLVERR);
	endtask : t_reset

	task t_illegal;
		wr(CTRL_ADDR, 32'h0, r);
		ev(EV_STOP);
		chk({seen, pw}, {5'h04, 10'h3A2});
		ev(EV_BGND);
		chk(debugActive, 1'b0);
	endtask : t_illegal

	task t_deep;
		logic [8:0] wk [3] = '{EV_IRQ, EV_RST, EV_TMR};
		for (int i = 0; i < 3; i++) begin
			wr(CTRL_ADDR, STP | DSL, r);
			ev(EV_STOP);
			chk(pw & 10'h3B7, 10'h015);
			ev(EV_MEM);
			chk(seen, 5'h02);
			ev(EV_BGND | EV_KPD | EV_LIGHT);
			chk(pw & 10'h3B7, 10'h015);
			ev(wk[i]);
			chk({seen, pw}, {5'h18, 10'h3A3});
			rd(STATUS_ADDR, d, r);
			chk(d, DWK);
			rd(CTRL_ADDR, d, r);
			chk(d, 32'h0);
			wr(ACK_ADDR, 32'h1 << ACK_RELEASE, r);
			rd(STATUS_ADDR, d, r);
			chk(d, 32'h0);
		end
	endtask : t_deep

	task t_light;
		wr(CTRL_ADDR, STP | DSL | LVE | LVS, r);
		ev(EV_STOP);
		chk(pw, 10'h04E);
		rd(CTRL_ADDR, d, r);
		chk(d, STP | DSL | LVE | LVS);
		rd(STATUS_ADDR, d, r);
		chk(d, {30'h0, MODE_LIGHT});
		ev(EV_KPD);
		chk({seen, pw}, {5'h00, 10'h3A2});
		wr(CTRL_ADDR, STP | OSK | ADK, r);
		ev(EV_STOP);
		chk(pw, 10'h07A);
		ev(EV_RST);
		chk({seen, pw[9]}, 6'h11);
	endtask : t_light

	task t_debug;
		wr(CTRL_ADDR, STP | DSL | DBG, r);
		ev(EV_STOP);
		chk(pw & 10'h3BF, 10'h1AE);
		ev(EV_MEM);
		chk(seen, 5'h02);
		ev(EV_BGND);
		rd(STATUS_ADDR, d, r);
		chk(d, {30'h0, MODE_DEBUG});
		ev(EV_MEM);
		chk(seen, 5'h01);
		ev(EV_GO);
		ev(EV_BGND);
		chk(debugActive, 1'b1);
		ev(EV_GO);
		chk(debugActive, 1'b0);
	endtask : t_debug

	task results;
		$display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// Holds reset for three cycles, then runs every scenario.
	initial begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_illegal();
		t_deep();
		t_light();
		t_debug();
		results();
	end
endmodule : tb_top
